//--- verilog/sapm_defs.svh
`ifndef SAPM_DEFS_SVH
`define SAPM_DEFS_SVH
// Register byte offsets
`define SAPM_CTRL_ADDR 8'h00
`define SAPM_BUS_LOW_ADDR 8'h04
`define SAPM_BUS_HIGH_ADDR 8'h08
`define SAPM_PEAK_ADDR 8'h0c
`define SAPM_NOM_ADDR 8'h10
`define SAPM_TAU_ADDR 8'h14
`define SAPM_HOLD_ADDR 8'h18
`define SAPM_STAT_ADDR 8'h1c
`define SAPM_MASK_ADDR 8'h20
`define SAPM_LIVE_ADDR 8'h24
// Control fields
`define SAPM_CTRL_EN_BIT 0
`define SAPM_CTRL_REDUCED_BIT 1
`define SAPM_CTRL_OFFBOARD_BIT 2
`define SAPM_CTRL_DC_BIT 3
`define SAPM_CTRL_BRSEL_BIT 4
`define SAPM_CTRL_FLIP_BIT 5
// Status fields
`define SAPM_ST_BUS_BIT 0
`define SAPM_ST_PEAK_BIT 1
`define SAPM_ST_THERM_BIT 2
`define SAPM_ST_PHASE_BIT 3
`define SAPM_ST_W 4
// Brake chopper offset below the upper limit, millivolts
`define SAPM_CHOP_OFFSET_MV 16'd10000
// Default thermal time constant shift and brake hold time in ms
`define SAPM_TAU_RST 5'd10
`define SAPM_HOLD_RST 16'h0000
`define SAPM_CLK_MHZ 250
`define SAPM_MS_CYCLES (`SAPM_CLK_MHZ * 1000)
`endif

//--- verilog/sapm_pkg.sv
package sapm_pkg;
    typedef enum logic [1:0] {
        SAPM_OFF = 2'b00,
        SAPM_RUN = 2'b01,
        SAPM_HOLD = 2'b11
    } sapm_state_t;
    typedef logic [15:0] sapm_word_t;
endpackage : sapm_pkg

//--- verilog/sapm_i2t_filter.sv
`include "sapm_defs.svh"
module sapm_i2t_filter #(
    parameter int CUR_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sample_i,
    input wire logic [CUR_W-1:0] mag_i,
    input wire logic [4:0] tau_shift_i,
    output logic [2*CUR_W-1:0] avg_o
);
    typedef struct packed {
        logic [2*CUR_W+31:0] acc;
    } sapm_flt_t;
    sapm_flt_t st_ff, nxt_st;
    logic [2*CUR_W-1:0] sq;
    logic [2*CUR_W+31:0] sq_ext;
    // Widen first: a bare product inside a concatenation keeps only CUR_W bits
    assign sq = (2*CUR_W)'(mag_i) * (2*CUR_W)'(mag_i);
    // Scaled accumulator keeps fractional bits so long time constants still move
    always_comb begin
        nxt_st = st_ff;
        sq_ext = {sq, 32'h0000_0000};
        if (sample_i) begin
            nxt_st.acc = st_ff.acc - (st_ff.acc >> tau_shift_i) + (sq_ext >> tau_shift_i);
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign avg_o = st_ff.acc[2*CUR_W+31:32];
endmodule : sapm_i2t_filter

//--- verilog/sapm_monitor.sv
// Functional notes
// - Bus voltage outside window raises error
// - Chopper switches 10 V below upper limit
// - Phase check: three required unless reduced allowed
// - Select internal or offboard dump resistor
// - Enabled axis drives selected brake output
// - Disable: brake first, hold enable delay
// - Flip motor direction when set
// - Current magnitude above peak raises error
// - Averaged phase current above nominal raises error
// - Current-square time is thermal time constant
`include "sapm_defs.svh"
module sapm_monitor #(
    parameter int CUR_W = 16,
    parameter int MS_CYCLES = `SAPM_MS_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [15:0] bus_mv_i,
    input wire logic [2:0] phase_ok_i,
    input wire logic signed [CUR_W-1:0] cur_a_i,
    input wire logic signed [CUR_W-1:0] cur_b_i,
    input wire logic signed [CUR_W-1:0] cur_c_i,
    input wire logic cur_valid_i,
    output logic stage_en_o,
    output logic motor_dir_flip_o,
    output logic three_phase_sync_type_o,
    output logic digital_output_one_o,
    output logic digital_output_two_o,
    output logic motor_connector_brake_o,
    output logic chopper_on_o,
    output logic offboard_dump_resistor_sel_o,
    output logic irq_o
);
    import sapm_pkg::*;
    localparam int ST_W = `SAPM_ST_W;
    typedef struct packed {
        logic [5:0] ctrl;
        sapm_word_t low;
        sapm_word_t high;
        logic [CUR_W-1:0] peak;
        logic [CUR_W-1:0] nom;
        logic [4:0] tau;
        sapm_word_t hold;
        logic [ST_W-1:0] stat;
        logic [ST_W-1:0] mask;
        sapm_state_t state;
        logic [31:0] tick;
        sapm_word_t ms_left;
        logic [31:0] rdat;
        logic ack;
        logic stage;
        logic flip;
        logic sync;
        logic out1;
        logic out2;
        logic conn;
        logic chop;
        logic offb;
        logic irq;
    } sapm_mon_t;
    sapm_mon_t st_ff, nxt_st;
    logic [2*CUR_W-1:0] avg_a, avg_b, avg_c;
    logic [CUR_W-1:0] mag_a, mag_b, mag_c;
    logic [ST_W-1:0] ev;
    logic wr, rd_hit;
    logic [31:0] wmask;
    logic [16:0] chop_thr;
    logic [2*CUR_W-1:0] nom_sq;
    function automatic logic [CUR_W-1:0] absv(input logic signed [CUR_W-1:0] v);
        absv = v[CUR_W-1] ? CUR_W'(-v) : CUR_W'(v);
    endfunction : absv
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [31:0] m);
        merge = (old & ~m) | (d & m);
    endfunction : merge
    assign mag_a = absv(cur_a_i);
    assign mag_b = absv(cur_b_i);
    assign mag_c = absv(cur_c_i);
    sapm_i2t_filter #(.CUR_W(CUR_W)) u_flt_a (.clk_i(clk_i), .rst_i(rst_i),
        .sample_i(cur_valid_i), .mag_i(mag_a), .tau_shift_i(st_ff.tau), .avg_o(avg_a));
    sapm_i2t_filter #(.CUR_W(CUR_W)) u_flt_b (.clk_i(clk_i), .rst_i(rst_i),
        .sample_i(cur_valid_i), .mag_i(mag_b), .tau_shift_i(st_ff.tau), .avg_o(avg_b));
    sapm_i2t_filter #(.CUR_W(CUR_W)) u_flt_c (.clk_i(clk_i), .rst_i(rst_i),
        .sample_i(cur_valid_i), .mag_i(mag_c), .tau_shift_i(st_ff.tau), .avg_o(avg_c));
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !st_ff.ack;
    assign chop_thr = {1'b0, st_ff.high} - {1'b0, `SAPM_CHOP_OFFSET_MV};
    // Square of the rating shared by all three phase compares
    assign nom_sq = (2*CUR_W)'(st_ff.nom) * (2*CUR_W)'(st_ff.nom);
    always_comb begin
        ev = '0;
        ev[`SAPM_ST_BUS_BIT] = (bus_mv_i < st_ff.low) || (bus_mv_i > st_ff.high);
        ev[`SAPM_ST_PEAK_BIT] = cur_valid_i && ((mag_a > st_ff.peak) || (mag_b > st_ff.peak)
                                || (mag_c > st_ff.peak));
        ev[`SAPM_ST_THERM_BIT] = (avg_a > nom_sq) || (avg_b > nom_sq)
                                 || (avg_c > nom_sq);
        // Reduced mode flags only when no phase is present; otherwise all three must be present
        ev[`SAPM_ST_PHASE_BIT] = st_ff.ctrl[`SAPM_CTRL_REDUCED_BIT] ? (phase_ok_i == 3'b000)
                                 : (phase_ok_i != 3'b111);
    end
    always_comb begin
        nxt_st = st_ff;
        rd_hit = 1'b1;
        nxt_st.ack = wb_cyc_i && wb_stb_i && !st_ff.ack;
        nxt_st.rdat = 32'h0000_0000;
        case (wb_adr_i)
            `SAPM_CTRL_ADDR: nxt_st.rdat = {26'h0, st_ff.ctrl};
            `SAPM_BUS_LOW_ADDR: nxt_st.rdat = {16'h0, st_ff.low};
            `SAPM_BUS_HIGH_ADDR: nxt_st.rdat = {16'h0, st_ff.high};
            `SAPM_PEAK_ADDR: nxt_st.rdat = 32'(st_ff.peak);
            `SAPM_NOM_ADDR: nxt_st.rdat = 32'(st_ff.nom);
            `SAPM_TAU_ADDR: nxt_st.rdat = {27'h0, st_ff.tau};
            `SAPM_HOLD_ADDR: nxt_st.rdat = {16'h0, st_ff.hold};
            `SAPM_STAT_ADDR: nxt_st.rdat = 32'(st_ff.stat);
            `SAPM_MASK_ADDR: nxt_st.rdat = 32'(st_ff.mask);
            `SAPM_LIVE_ADDR: nxt_st.rdat = {24'h0, 3'h0, ev, st_ff.state == SAPM_HOLD};
            default: rd_hit = 1'b0;
        endcase
        // Read data stands the cycle after each sampled read request, with or without ack; writes and unmapped reads return zero
        if (!(wb_cyc_i && wb_stb_i) || wb_we_i || !rd_hit) begin
            nxt_st.rdat = 32'h0000_0000;
        end
        // Set wins over a simultaneous write-one clear
        nxt_st.stat = st_ff.stat | ev;
        if (wr) begin
            case (wb_adr_i)
                `SAPM_CTRL_ADDR: nxt_st.ctrl = 6'(merge(32'(st_ff.ctrl), wb_dat_i, wmask));
                `SAPM_BUS_LOW_ADDR: nxt_st.low = 16'(merge(32'(st_ff.low), wb_dat_i, wmask));
                `SAPM_BUS_HIGH_ADDR: nxt_st.high = 16'(merge(32'(st_ff.high), wb_dat_i, wmask));
                `SAPM_PEAK_ADDR: nxt_st.peak = CUR_W'(merge(32'(st_ff.peak), wb_dat_i, wmask));
                `SAPM_NOM_ADDR: nxt_st.nom = CUR_W'(merge(32'(st_ff.nom), wb_dat_i, wmask));
                `SAPM_TAU_ADDR: nxt_st.tau = 5'(merge(32'(st_ff.tau), wb_dat_i, wmask));
                `SAPM_HOLD_ADDR: nxt_st.hold = 16'(merge(32'(st_ff.hold), wb_dat_i, wmask));
                `SAPM_STAT_ADDR: begin
                    if (wb_sel_i[0]) begin
                        nxt_st.stat = (st_ff.stat & ~wb_dat_i[ST_W-1:0]) | ev;
                    end
                end
                `SAPM_MASK_ADDR: begin
                    if (wb_sel_i[0]) begin
                        nxt_st.mask = wb_dat_i[ST_W-1:0];
                    end
                end
                default: ;
            endcase
        end
        // Axis sequencer; any latched error forces power stage off
        if (st_ff.tick != 32'h0) begin
            nxt_st.tick = st_ff.tick - 32'h1;
        end
        case (st_ff.state)
            SAPM_OFF: begin
                if (st_ff.ctrl[`SAPM_CTRL_EN_BIT] && st_ff.stat == '0) begin
                    nxt_st.state = SAPM_RUN;
                end
            end
            SAPM_RUN: begin
                if (st_ff.stat != '0) begin
                    nxt_st.state = SAPM_OFF;
                end else if (!st_ff.ctrl[`SAPM_CTRL_EN_BIT]) begin
                    nxt_st.state = SAPM_HOLD;
                    nxt_st.ms_left = st_ff.hold;
                    nxt_st.tick = 32'(MS_CYCLES - 1);
                end
            end
            SAPM_HOLD: begin
                if (st_ff.stat != '0 || st_ff.ms_left == 16'h0) begin
                    nxt_st.state = SAPM_OFF;
                end else if (st_ff.tick == 32'h0) begin
                    nxt_st.ms_left = st_ff.ms_left - 16'h1;
                    nxt_st.tick = 32'(MS_CYCLES - 1);
                end
            end
            default: nxt_st.state = SAPM_OFF;
        endcase
        nxt_st.stage = (nxt_st.state != SAPM_OFF);
        nxt_st.out1 = (nxt_st.state == SAPM_RUN) && !st_ff.ctrl[`SAPM_CTRL_BRSEL_BIT];
        nxt_st.conn = nxt_st.out1;
        nxt_st.out2 = (nxt_st.state == SAPM_RUN) && st_ff.ctrl[`SAPM_CTRL_BRSEL_BIT];
        nxt_st.flip = st_ff.ctrl[`SAPM_CTRL_FLIP_BIT];
        nxt_st.sync = !st_ff.ctrl[`SAPM_CTRL_DC_BIT];
        nxt_st.offb = st_ff.ctrl[`SAPM_CTRL_OFFBOARD_BIT];
        nxt_st.chop = !chop_thr[16] && ({1'b0, bus_mv_i} > chop_thr);
        nxt_st.irq = |(nxt_st.stat & st_ff.mask);
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
            st_ff.tau <= `SAPM_TAU_RST;
            st_ff.hold <= `SAPM_HOLD_RST;
            st_ff.high <= 16'hffff;
            st_ff.peak <= '1;
            st_ff.nom <= '1;
            st_ff.state <= SAPM_OFF;
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign wb_dat_o = st_ff.rdat;
    assign wb_ack_o = st_ff.ack;
    assign stage_en_o = st_ff.stage;
    assign motor_dir_flip_o = st_ff.flip;
    assign three_phase_sync_type_o = st_ff.sync;
    assign digital_output_one_o = st_ff.out1;
    assign digital_output_two_o = st_ff.out2;
    assign motor_connector_brake_o = st_ff.conn;
    assign chopper_on_o = st_ff.chop;
    assign offboard_dump_resistor_sel_o = st_ff.offb;
    assign irq_o = st_ff.irq;

    // Checks sample registered state, so those driven by inputs expect their effect one edge later
    bus_window_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_mv_i > st_ff.high) |=> st_ff.stat[`SAPM_ST_BUS_BIT])
        else $error("bus window error not raised");
    bus_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_mv_i < st_ff.low) |=> st_ff.stat[`SAPM_ST_BUS_BIT])
        else $error("low bus error not raised");
    bus_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!st_ff.stat[`SAPM_ST_BUS_BIT] && bus_mv_i >= st_ff.low && bus_mv_i <= st_ff.high)
        |=> !st_ff.stat[`SAPM_ST_BUS_BIT])
        else $error("bus error inside window");
    chop_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_ff.high > 16'd20000 && bus_mv_i > st_ff.high - 16'd10000) |=> chopper_on_o)
        else $error("chopper not on above threshold");
    chop_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_ff.high >= `SAPM_CHOP_OFFSET_MV && bus_mv_i <= st_ff.high - `SAPM_CHOP_OFFSET_MV)
        |=> !chopper_on_o)
        else $error("chopper on below threshold");
    phase_miss_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!st_ff.ctrl[1] && phase_ok_i == 3'b011) |=> st_ff.stat[3])
        else $error("missing phase not flagged");
    phase_ok_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_ff.ctrl[1] && phase_ok_i != 3'b000 && !st_ff.stat[3]) |=> !st_ff.stat[3])
        else $error("reduced phase wrongly flagged");
    dump_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 offboard_dump_resistor_sel_o == $past(st_ff.ctrl[2]))
        else $error("resistor select mismatch");
    brake_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (digital_output_one_o || digital_output_two_o) |-> stage_en_o)
        else $error("brake released while stage off");
    brake_excl_a: assert property (@(posedge clk_i) disable iff (rst_i)
        digital_output_two_o |-> !digital_output_one_o)
        else $error("both brake outputs set");
    conn_match_a: assert property (@(posedge clk_i) disable iff (rst_i)
        motor_connector_brake_o == digital_output_one_o)
        else $error("connector brake differs from output one");
    run_stage_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_ff.state == SAPM_RUN) |-> stage_en_o)
        else $error("stage off while running");
    hold_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ($fell(digital_output_one_o) && st_ff.state == SAPM_HOLD && st_ff.hold != 16'h0)
        |-> stage_en_o [*8])
        else $error("stage dropped before hold time");
    hold_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_ff.state == SAPM_HOLD) |-> !digital_output_one_o && !digital_output_two_o)
        else $error("brake still released in hold");
    dir_flip_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 motor_dir_flip_o == $past(st_ff.ctrl[5]))
        else $error("direction flip mismatch");
    peak_err_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (cur_valid_i && mag_a > st_ff.peak) |=> st_ff.stat[1] ##1 !stage_en_o)
        else $error("peak error not latched");
    peak_b_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (cur_valid_i && mag_b > st_ff.peak) |=> st_ff.stat[`SAPM_ST_PEAK_BIT])
        else $error("phase b peak not flagged");
    therm_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (avg_a > nom_sq) |=> st_ff.stat[`SAPM_ST_THERM_BIT])
        else $error("thermal error not raised");
    err_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_ff.stat[2] && !(wr && wb_adr_i == `SAPM_STAT_ADDR)) |=> st_ff.stat[2])
        else $error("thermal error dropped");
    peak_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_ff.stat[1] && !(wr && wb_adr_i == `SAPM_STAT_ADDR)) |=> st_ff.stat[1])
        else $error("peak error dropped");
    fault_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_ff.stat != '0) |=> !stage_en_o)
        else $error("stage on with latched error");
    irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o == |(st_ff.stat & $past(st_ff.mask)))
        else $error("interrupt level mismatch");
    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    run_cov_c: cover property (@(posedge clk_i) st_ff.state == SAPM_RUN);
    therm_cov_c: cover property (@(posedge clk_i) $rose(st_ff.stat[`SAPM_ST_THERM_BIT]));
    hold_cov_c: cover property (@(posedge clk_i) st_ff.state == SAPM_HOLD ##1 !stage_en_o);
    chop_cov_c: cover property (@(posedge clk_i) $rose(chopper_on_o));
    irq_cov_c: cover property (@(posedge clk_i) $rose(irq_o));
endmodule : sapm_monitor

//--- verification/sapm_power_model.sv
module sapm_power_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic stage_en_i,
    input wire logic [15:0] bus_set_i,
    input wire logic [2:0] phase_set_i,
    input wire logic signed [15:0] amp_i,
    output logic [15:0] bus_mv_o,
    output logic [2:0] phase_ok_o,
    output logic signed [15:0] cur_a_o,
    output logic signed [15:0] cur_b_o,
    output logic signed [15:0] cur_c_o,
    output logic cur_valid_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] tick_ff;
    // No current without a powered stage, so a fault really stops the motor
    always_ff @(posedge clk_i) begin
        tick_ff <= rst_i ? 2'h0 : tick_ff + 2'h1;
        cur_valid_o <= !rst_i && tick_ff == 2'h3;
        cur_a_o <= stage_en_i ? amp_i : 16'sh0;
        cur_b_o <= stage_en_i ? -amp_i : 16'sh0;
        cur_c_o <= 16'sh0;
        bus_mv_o <= bus_set_i;
        phase_ok_o <= phase_set_i;
    end
endmodule : sapm_power_model

//--- verification/tb_sapm_monitor.sv
`include "sapm_defs.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_sapm_monitor;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, rdat;
    logic ack, stage, flip, sync, out1, out2, conn, chop, offb, irq, valid;
    logic [15:0] bus_set = 16'hafc8, bus_mv;
    logic [2:0] phase_set = 3'h7, phase_ok;
    logic signed [15:0] amp = 16'sh0, ca, cb, cc;
    int miscompares = 0, checks_done = 0, cycles = 0;
    sapm_monitor #(.MS_CYCLES(4)) sapm_monitor_i (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .bus_mv_i(bus_mv),
        .phase_ok_i(phase_ok), .cur_a_i(ca), .cur_b_i(cb), .cur_c_i(cc), .cur_valid_i(valid),
        .stage_en_o(stage), .motor_dir_flip_o(flip), .three_phase_sync_type_o(sync),
        .digital_output_one_o(out1), .digital_output_two_o(out2),
        .motor_connector_brake_o(conn), .chopper_on_o(chop),
        .offboard_dump_resistor_sel_o(offb), .irq_o(irq));
    sapm_power_model sapm_power_model_i (.clk_i(clk_i), .rst_i(rst_i), .stage_en_i(stage),
        .bus_set_i(bus_set), .phase_set_i(phase_set), .amp_i(amp), .bus_mv_o(bus_mv),
        .phase_ok_o(phase_ok), .cur_a_o(ca), .cur_b_o(cb), .cur_c_o(cc), .cur_valid_o(valid));
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            close_out();
        end
    end
    task automatic cw(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cw
    // Classic single cycle; the answer time is never assumed
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        if (n == 50) miscompares++;
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        `CHK(n, e, q)
    endtask : rd
    task automatic t_reset();
        `CHK("stage", 1'b0, stage)
        `CHK("sync", 1'b1, sync)
        `CHK("irq", 1'b0, irq)
        rd(`SAPM_CTRL_ADDR, 32'h0, "ctrl");
        rd(`SAPM_BUS_LOW_ADDR, 32'h0, "low");
        rd(`SAPM_BUS_HIGH_ADDR, 32'hffff, "high");
        rd(`SAPM_PEAK_ADDR, 32'hffff, "peak");
        rd(`SAPM_NOM_ADDR, 32'hffff, "nom");
        rd(`SAPM_TAU_ADDR, 32'ha, "tau");
        rd(`SAPM_HOLD_ADDR, 32'h0, "hold");
        wr(8'h30, 32'h5);
        rd(8'h30, 32'h0, "unmapped");
        $display("reset test done");
    endtask : t_reset
    task automatic t_config();
        // Pole pairs and line counts feed commutation, outside this block
        wr(`SAPM_CTRL_ADDR, 32'h2c);
        cw(2);
        `CHK("offboard", 1'b1, offb)
        `CHK("dc type", 1'b0, sync)
        `CHK("flip", 1'b1, flip)
        wr(`SAPM_CTRL_ADDR, 32'h0);
        cw(2);
        `CHK("internal", 1'b0, offb)
        `CHK("ac type", 1'b1, sync)
        `CHK("no flip", 1'b0, flip)
        $display("config test done");
    endtask : t_config
    task automatic t_brake();
        logic s;
        wr(`SAPM_HOLD_ADDR, 32'h2);
        for (int i = 0; i < 2; i++) begin
            s = i[0];
            wr(`SAPM_CTRL_ADDR, {27'h0, s, 4'h1});
            cw(4);
            `CHK("run stage", 1'b1, stage)
            `CHK("out one", !s, out1)
            `CHK("connector", !s, conn)
            `CHK("out two", s, out2)
            wr(`SAPM_CTRL_ADDR, {27'h0, s, 4'h0});
            `CHK("brake first", 2'b00, {out1, out2})
            `CHK("held stage", 1'b1, stage)
            cw(6);
            `CHK("still held", 1'b1, stage)
            cw(8);
            `CHK("stage off", 1'b0, stage)
        end
        $display("brake test done");
    endtask : t_brake
    task automatic t_window();
        wr(`SAPM_BUS_LOW_ADDR, 32'd38000);
        wr(`SAPM_BUS_HIGH_ADDR, 32'd52000);
        wr(`SAPM_MASK_ADDR, 32'hf);
        bus_set <= 16'd40000;
        cw(4);
        `CHK("chop below", 1'b0, chop)
        bus_set <= 16'd42001;
        cw(4);
        `CHK("chop above", 1'b1, chop)
        rd(`SAPM_STAT_ADDR, 32'h0, "in window");
        bus_set <= 16'd53000;
        cw(4);
        `CHK("irq", 1'b1, irq)
        wr(`SAPM_STAT_ADDR, 32'h1);
        rd(`SAPM_STAT_ADDR, 32'h1, "over high");
        bus_set <= 16'd45000;
        cw(4);
        wr(`SAPM_STAT_ADDR, 32'h1);
        rd(`SAPM_STAT_ADDR, 32'h0, "cleared");
        `CHK("irq low", 1'b0, irq)
        bus_set <= 16'd37000;
        cw(4);
        rd(`SAPM_STAT_ADDR, 32'h1, "below low");
        bus_set <= 16'd45000;
        cw(4);
        wr(`SAPM_STAT_ADDR, 32'h1);
        $display("window test done");
    endtask : t_window
    task automatic t_phase();
        phase_set <= 3'b011;
        cw(4);
        rd(`SAPM_STAT_ADDR, 32'h8, "lost phase");
        wr(`SAPM_CTRL_ADDR, 32'h2);
        phase_set <= 3'b001;
        cw(4);
        wr(`SAPM_STAT_ADDR, 32'h8);
        rd(`SAPM_STAT_ADDR, 32'h0, "one phase ok");
        phase_set <= 3'b000;
        cw(4);
        rd(`SAPM_STAT_ADDR, 32'h8, "no phase");
        phase_set <= 3'b111;
        wr(`SAPM_CTRL_ADDR, 32'h0);
        wr(`SAPM_STAT_ADDR, 32'h8);
        $display("phase test done");
    endtask : t_phase
    task automatic t_current();
        wr(`SAPM_PEAK_ADDR, 32'd1414);
        wr(`SAPM_CTRL_ADDR, 32'h1);
        amp <= 16'sd1414;
        cw(12);
        rd(`SAPM_STAT_ADDR, 32'h0, "at peak");
        amp <= 16'sd1415;
        cw(12);
        rd(`SAPM_STAT_ADDR, 32'h2, "over peak");
        `CHK("fault stage", 1'b0, stage)
        amp <= 16'sh0;
        wr(`SAPM_CTRL_ADDR, 32'h0);
        wr(`SAPM_STAT_ADDR, 32'h2);
        wr(`SAPM_PEAK_ADDR, 32'hffff);
        // Let the filters forget the peak run before the rating drops
        wr(`SAPM_TAU_ADDR, 32'h4);
        cw(200);
        wr(`SAPM_NOM_ADDR, 32'd100);
        amp <= 16'sd200;
        wr(`SAPM_CTRL_ADDR, 32'h1);
        cw(6);
        rd(`SAPM_STAT_ADDR, 32'h0, "still cool");
        cw(60);
        rd(`SAPM_STAT_ADDR, 32'h4, "overheated");
        `CHK("therm stage", 1'b0, stage)
        amp <= 16'sh0;
        wr(`SAPM_CTRL_ADDR, 32'h0);
        wr(`SAPM_NOM_ADDR, 32'hffff);
        wr(`SAPM_STAT_ADDR, 32'h4);
        rd(`SAPM_STAT_ADDR, 32'h0, "therm clear");
        $display("current test done");
    endtask : t_current
    initial begin
        cw(3);
        rst_i <= 1'b0;
        cw(2);
        t_reset();
        t_config();
        t_brake();
        t_window();
        t_phase();
        t_current();
        close_out();
    end
endmodule : tb_sapm_monitor
